// >>> rtl/stm_timer.sv
// Standard timer: 10-bit counter, compare, PWM, single pulse and capture, AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "stm_params.svh"
module stm_timer
	import stm_pkg::*;
#(
	parameter int CW = 10
) (
	// Clock, reset, enable
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic CE,
	// Timer pins
	input wire logic CAPTURE_INPUT,
	input wire logic EXTERNAL_TRIGGER_PIN,
	output logic TIMER_OUT,
	output logic TIMER_OUT_EN,
	// AXI4-Lite write address, data and response
	input wire logic [11:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	// AXI4-Lite read
	input wire logic [11:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY
);
	// Register state
	logic [7:0] ctrl0;
	logic [7:0] ctrl1;
	logic [CW-1:0] compare_a_value;
	logic [1:0] flags;
	logic [CW-1:0] count;
	logic on_prev;
	logic pin;
	logic cap_prev;
	logic cap_pend;
	logic [7:0] next_ctrl0;
	logic [7:0] next_ctrl1;
	logic [CW-1:0] next_compare_a_value;
	logic [1:0] next_flags;
	logic [CW-1:0] next_count;
	logic next_on_prev;
	logic next_pin;
	logic next_cap_prev;
	logic next_cap_pend;
	// Bus state
	stm_bus_t wst, rst_st, next_wst, next_rst_st;
	logic aw_got, w_got, next_aw_got, next_w_got;
	logic [11:0] aw_q, next_aw_q;
	logic [31:0] w_q, next_w_q;
	logic [3:0] ws_q, next_ws_q;
	logic [1:0] next_bresp;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// Decoded fields
	stm_mode_t mode;
	logic [1:0] func;
	logic counter_on;
	logic [2:0] compare_p_value;
	logic on_rise;
	logic pulse_mode;
	logic pwm_mode;
	logic [CW:0] p_count;
	logic p_match;
	logic a_match, a_end;
	logic wr_fire;

	assign mode = stm_mode_t'(ctrl1[`STM_C1_MODE_MSB:`STM_C1_MODE_LSB]);
	assign func = ctrl1[`STM_C1_FUNC_MSB:`STM_C1_FUNC_LSB];
	assign counter_on = ctrl0[`STM_C0_ON];
	assign compare_p_value = ctrl0[`STM_C0_COMPARE_P_VALUE_MSB:0];
	assign on_rise = counter_on && !on_prev;
	assign pwm_mode = (mode == STM_MODE_PWM) && (func != 2'h3);
	assign pulse_mode = (mode == STM_MODE_PWM) && (func == 2'h3);

	// Period count of comparator P: 128 per step, zero meaning full range
	function automatic logic [CW:0] p_to_count(input logic [2:0] p);
		p_to_count = (p == 3'h0) ? {1'b1, {CW{1'b0}}}
			: (CW+1)'({p, 7'h00});
	endfunction : p_to_count

	assign p_count = p_to_count(compare_p_value);
	// P match on the last count keeps the period at exactly 128 times P; zero P wraps at 3FF
	assign p_match = ((CW+1)'(count) + 1'b1) == p_count;
	// A zero never matches: counter then overflows with no A flag
	assign a_match = (compare_a_value != '0) && (count == compare_a_value);
	assign a_end = ((CW+1)'(count) + 1'b1) == (CW+1)'(compare_a_value); // Last count of an A-set period

	// Timer core next-state
	always_comb begin
		logic clr, run, fl_a, fl_p, cap_edge, active;
		logic [CW:0] duty, period;
		clr = 1'b0;
		fl_a = 1'b0;
		fl_p = 1'b0;
		cap_edge = 1'b0;
		duty = '0;
		period = '0;
		active = 1'b0;
		run = counter_on && !on_rise;
		next_ctrl0 = ctrl0;
		next_ctrl1 = ctrl1;
		next_compare_a_value = compare_a_value;
		next_flags = flags;
		next_count = count;
		next_on_prev = counter_on;
		next_pin = pin;
		next_cap_prev = CAPTURE_INPUT;
		next_cap_pend = 1'b0;
		if (on_rise) begin
			next_count = '0;
		end else if (run) begin
			unique case (mode)
				STM_MODE_CMP, STM_MODE_TMR: begin
					if (ctrl1[`STM_C1_CCLR]) begin
						clr = a_match;
						fl_a = a_match;
					end else begin
						clr = p_match;
						fl_a = a_match;
						fl_p = p_match;
					end
				end
				STM_MODE_PWM: begin
					if (pulse_mode) begin
						fl_a = a_match;
					end else begin
						// Swap chooses the period comparator; clear_select ignored
						clr = ctrl1[`STM_C1_DPX] ? a_end : p_match;
						fl_a = ctrl1[`STM_C1_DPX] ? a_end : a_match;
						fl_p = p_match;
					end
				end
				STM_MODE_CAP: begin
					clr = p_match;
					fl_p = p_match;
				end
			endcase
			next_count = clr ? '0 : CW'(count + 1'b1);
		end
		// Capture edge select, delayed one cycle to separate latch and flag
		if (mode == STM_MODE_CAP && counter_on) begin
			unique case (func)
				2'h0: cap_edge = CAPTURE_INPUT && !cap_prev;
				2'h1: cap_edge = !CAPTURE_INPUT && cap_prev;
				2'h2: cap_edge = CAPTURE_INPUT != cap_prev;
				2'h3: cap_edge = 1'b0;
			endcase
		end
		if (cap_edge) begin
			next_compare_a_value = count;
			next_cap_pend = 1'b1;
		end
		if (cap_pend) begin
			fl_a = 1'b1;
		end
		// Pin behaviour per mode
		if (mode == STM_MODE_CMP) begin
			if (on_rise) begin
				next_pin = ctrl1[`STM_C1_OC];
			end else if (fl_a) begin
				unique case (func)
					2'h0: next_pin = pin;
					2'h1: next_pin = 1'b0;
					2'h2: next_pin = 1'b1;
					2'h3: next_pin = !pin;
				endcase
			end
		end else if (pwm_mode) begin
			// Duty compare against period; duty at or above period stays active
			duty = ctrl1[`STM_C1_DPX] ? p_count : (CW+1)'(compare_a_value);
			period = ctrl1[`STM_C1_DPX] ? (CW+1)'(compare_a_value) : p_count;
			active = ((CW+1)'(next_count) < duty) || (duty >= period);
			if (!counter_on) begin
				active = 1'b0;
			end
			if (func == 2'h0) begin
				active = 1'b0;
			end else if (func == 2'h1) begin
				active = 1'b1;
			end
			next_pin = active ? ctrl1[`STM_C1_OC] : !ctrl1[`STM_C1_OC];
		end else if (pulse_mode) begin
			// Leading edge on start, trailing edge on stop
			next_pin = (counter_on && !(run && a_match)) ? ctrl1[`STM_C1_OC]
				: !ctrl1[`STM_C1_OC];
		end
		// Hardware sets flags; set wins over a software clear below
		next_flags[`STM_FL_A] = flags[`STM_FL_A] | fl_a;
		next_flags[`STM_FL_P] = flags[`STM_FL_P] | fl_p;
		// Software writes
		if (wr_fire && ws_q[0]) begin
			if (aw_q == `STM_OFS_CTRL0) begin
				next_ctrl0 = w_q[7:0];
			end else if (aw_q == `STM_OFS_CTRL1) begin
				next_ctrl1 = w_q[7:0];
			end else if (aw_q == `STM_OFS_COMPARE_A_VALUE && !cap_edge) begin
				next_compare_a_value[7:0] = w_q[7:0]; // Lane 0 carries the low byte only
			end else if (aw_q == `STM_OFS_FLAGS) begin
				// Write one to clear
				next_flags[`STM_FL_A] = (flags[`STM_FL_A] & !w_q[0]) | fl_a;
				next_flags[`STM_FL_P] = (flags[`STM_FL_P] & !w_q[1]) | fl_p;
			end
		end
		if (wr_fire && ws_q[1] && aw_q == `STM_OFS_COMPARE_A_VALUE && !cap_edge) begin
			next_compare_a_value[CW-1:8] = w_q[CW-1:8];
		end
		// Trigger pin starts a pulse; A match ends it
		if (pulse_mode && EXTERNAL_TRIGGER_PIN) begin
			next_ctrl0[`STM_C0_ON] = 1'b1;
		end
		if (pulse_mode && run && a_match) begin
			next_ctrl0[`STM_C0_ON] = 1'b0;
		end
	end

	// Timer core registers
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			ctrl0 <= `STM_CTRL_RST;
			ctrl1 <= `STM_CTRL_RST;
			compare_a_value <= '0;
			flags <= 2'h0;
			count <= '0;
			on_prev <= 1'b0;
			pin <= 1'b0;
			cap_prev <= 1'b0;
			cap_pend <= 1'b0;
		end else if (CE) begin
			ctrl0 <= next_ctrl0;
			ctrl1 <= next_ctrl1;
			compare_a_value <= next_compare_a_value;
			flags <= next_flags;
			count <= next_count;
			on_prev <= next_on_prev;
			pin <= next_pin;
			cap_prev <= next_cap_prev;
			cap_pend <= next_cap_pend;
		end
	end

	// Pin drive: invert applies outside capture mode; the pin is released in timer/counter and capture modes
	assign TIMER_OUT = pin ^ (ctrl1[`STM_C1_POL] && mode != STM_MODE_CAP);
	assign TIMER_OUT_EN = (mode != STM_MODE_TMR) && (mode != STM_MODE_CAP);

	// Bus handshakes: address and data accepted in either order
	assign AWREADY = (wst == STM_BUS_IDLE) && !aw_got && CE;
	assign WREADY = (wst == STM_BUS_IDLE) && !w_got && CE;
	assign ARREADY = (rst_st == STM_BUS_IDLE) && CE;
	assign BVALID = (wst == STM_BUS_RESP);
	assign RVALID = (rst_st == STM_BUS_RESP);
	assign wr_fire = (wst == STM_BUS_IDLE) && aw_got && w_got;

	// Bus next-state
	always_comb begin
		next_wst = wst;
		next_rst_st = rst_st;
		next_aw_got = aw_got;
		next_w_got = w_got;
		next_aw_q = aw_q;
		next_w_q = w_q;
		next_ws_q = ws_q;
		next_bresp = BRESP;
		next_rdata = RDATA;
		next_rresp = RRESP;
		if (AWVALID && AWREADY) begin
			next_aw_got = 1'b1;
			next_aw_q = {AWADDR[11:2], 2'b00};
		end
		if (WVALID && WREADY) begin
			next_w_got = 1'b1;
			next_w_q = WDATA;
			next_ws_q = WSTRB;
		end
		if (wr_fire) begin
			next_aw_got = 1'b0;
			next_w_got = 1'b0;
			next_wst = STM_BUS_RESP;
			next_bresp = (aw_q > `STM_OFS_FLAGS) ? `STM_RESP_SLVERR : `STM_RESP_OKAY;
		end else if (wst == STM_BUS_RESP && BREADY) begin
			next_wst = STM_BUS_IDLE;
		end
		if (ARVALID && ARREADY) begin
			next_rst_st = STM_BUS_RESP;
			next_rresp = `STM_RESP_OKAY;
			unique case ({ARADDR[11:2], 2'b00})
				`STM_OFS_CTRL0: next_rdata = {24'h000000, ctrl0};
				`STM_OFS_CTRL1: next_rdata = {24'h000000, ctrl1};
				`STM_OFS_COUNT: next_rdata = 32'(count);
				`STM_OFS_COMPARE_A_VALUE: next_rdata = 32'(compare_a_value);
				`STM_OFS_FLAGS: next_rdata = {30'h00000000, flags};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = `STM_RESP_SLVERR;
				end
			endcase
		end else if (rst_st == STM_BUS_RESP && RREADY) begin
			next_rst_st = STM_BUS_IDLE;
		end
	end

	// Bus registers
	always_ff @(posedge CLK_SYS or negedge NRST) begin
		if (!NRST) begin
			wst <= STM_BUS_IDLE;
			rst_st <= STM_BUS_IDLE;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= 12'h000;
			w_q <= 32'h00000000;
			ws_q <= 4'h0;
			BRESP <= 2'h0;
			RDATA <= 32'h00000000;
			RRESP <= 2'h0;
		end else if (CE) begin
			wst <= next_wst;
			rst_st <= next_rst_st;
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			aw_q <= next_aw_q;
			w_q <= next_w_q;
			ws_q <= next_ws_q;
			BRESP <= next_bresp;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
		end
	end

	// Checks
	a_cmp_pclear: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && counter_on && !on_rise && mode == STM_MODE_CMP && !ctrl1[0] && p_match
		|=> !CE || count == '0) else $error("P match did not clear counter");
	a_cclr_noflag: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && mode == STM_MODE_CMP && ctrl1[0] && !flags[1] && !wr_fire
		|=> !flags[1]) else $error("P flag set with clear_select high");
	a_zero_anomatch: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && mode == STM_MODE_CMP && compare_a_value == '0 && !flags[0] && !cap_pend && !wr_fire
		|=> !flags[0]) else $error("A flag raised with compare value zero");
	a_on_initial: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && on_rise && mode == STM_MODE_CMP
		|=> !CE || pin == $past(ctrl1[3])) else $error("Pin not initialised");
	a_spulse_stop: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && pulse_mode && counter_on && !on_rise && a_match && !EXTERNAL_TRIGGER_PIN
		&& !wr_fire |=> !CE || (!counter_on && flags[0])) else $error("Pulse not ended");
	a_cap_latch: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && mode == STM_MODE_CAP && counter_on && func == 2'h0
		&& CAPTURE_INPUT && !cap_prev |=> compare_a_value == $past(count)) else $error("Capture lost");
	a_cap_flag: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && cap_pend |=> flags[0]) else $error("Capture flag missing");
	a_count_hold: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && !counter_on && !on_prev |=> count == $past(count)) else $error("Count moved while off");
	a_pwm_full: assert property (@(posedge CLK_SYS) disable iff (!NRST)
		CE && pwm_mode && func == 2'h2 && counter_on && !ctrl1[1] && compare_a_value >= p_count && !wr_fire
		&& $stable(ctrl1) && $stable(ctrl0) |=> pin == ctrl1[3]) else $error("Not full duty");
endmodule : stm_timer

// >>> common/stm_params.svh
// Register offsets, field positions, reset values and timing counts of the standard timer
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH
`define STM_OFS_CTRL0 12'h000
`define STM_OFS_CTRL1 12'h004
`define STM_OFS_COUNT 12'h008
`define STM_OFS_COMPARE_A_VALUE 12'h00C
`define STM_OFS_FLAGS 12'h010
`define STM_C0_ON 3
`define STM_C0_COMPARE_P_VALUE_MSB 2
`define STM_C1_MODE_MSB 7
`define STM_C1_MODE_LSB 6
`define STM_C1_FUNC_MSB 5
`define STM_C1_FUNC_LSB 4
`define STM_C1_OC 3
`define STM_C1_POL 2
`define STM_C1_DPX 1
`define STM_C1_CCLR 0
`define STM_FL_A 0
`define STM_FL_P 1
`define STM_CTRL_RST 8'h00
`define STM_CNT_MAX 10'h3FF
`define STM_P_SHIFT 7
`define STM_RESP_OKAY 2'h0
`define STM_RESP_SLVERR 2'h2
`endif

// >>> common/stm_pkg.sv
// Types shared by the standard timer
package stm_pkg;
	typedef enum logic [1:0] {
		STM_MODE_CMP = 2'h0,
		STM_MODE_CAP = 2'h1,
		STM_MODE_PWM = 2'h2,
		STM_MODE_TMR = 2'h3
	} stm_mode_t;
	typedef enum logic [1:0] {
		STM_BUS_IDLE = 2'h0,
		STM_BUS_RESP = 2'h1
	} stm_bus_t;
endpackage : stm_pkg

// >>> verif/stm_pin_model.sv
// Pin partner: drives capture and trigger lines, loads the timer output
`timescale 1ns/1ps
module stm_pin_model (
	// Clock
	input wire logic CLK_SYS,
	// Timer output side
	input wire logic PIN,
	input wire logic PIN_EN,
	// Timer input side
	output logic CAP,
	output logic TRIG
);
	// Both lines rest low, as with a pull-down
	initial begin
		CAP = 1'h0;
		TRIG = 1'h0;
	end
	// Each level stands 4 clocks so no edge is too short to be seen
	task automatic set_cap(input logic v);
		@(posedge CLK_SYS);
		CAP <= v;
		repeat (4) @(posedge CLK_SYS);
	endtask : set_cap
	// Short pulse; a level held high would restart the shot
	task automatic trigger();
		@(posedge CLK_SYS);
		TRIG <= 1'h1;
		repeat (2) @(posedge CLK_SYS);
		TRIG <= 1'h0;
	endtask : trigger
	// Counts driven high cycles, sampled mid-cycle
	task automatic measure(input int n, output int hi);
		hi = 0;
		repeat (n) begin
			@(negedge CLK_SYS);
			if (PIN === 1'h1 && PIN_EN === 1'h1) hi++;
		end
	endtask : measure
endmodule : stm_pin_model

// >>> verif/tb_stm_timer.sv
// Self-checking bench for the standard timer
`timescale 1ns/1ps
`include "stm_params.svh"
module tb_stm_timer
	import stm_pkg::*;
();
	logic CLK_SYS = 1'h0;
	logic NRST, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic CAPTURE_INPUT, EXTERNAL_TRIGGER_PIN, TIMER_OUT, TIMER_OUT_EN;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd_data, keep;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP, resp;
	int bad_count = 0;
	int compares = 0;
	int hi, k;
	// PWM cases: control, A value, P value, window, high cycles, flags
	logic [7:0] pw_c [8] = '{8'hA8, 8'hA8, 8'hAA, 8'hAC, 8'h88, 8'h98, 8'hA8, 8'hA0};
	logic [9:0] pw_a [8] = '{10'h20, 10'hC8, 10'h100, 10'h20, 10'h20, 10'h20, 10'h100, 10'h20};
	logic [2:0] pw_p [8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1};
	int pw_w [8] = '{128, 128, 256, 128, 128, 128, 1024, 128};
	int pw_h [8] = '{32, 128, 128, 96, 0, 128, 256, 96};
	logic [1:0] pw_f [8] = '{2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

	// 50 ns clock
	always #25 CLK_SYS = ~CLK_SYS;

	stm_timer dut_u (.CLK_SYS, .NRST, .CE, .CAPTURE_INPUT, .EXTERNAL_TRIGGER_PIN, .TIMER_OUT,
		.TIMER_OUT_EN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP,
		.BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
	stm_pin_model pm_u (.CLK_SYS(CLK_SYS), .PIN(TIMER_OUT), .PIN_EN(TIMER_OUT_EN),
		.CAP(CAPTURE_INPUT), .TRIG(EXTERNAL_TRIGGER_PIN));

	task automatic conclude();
		if (bad_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// A hung handshake counts once, then ends the run
	task automatic stall();
		cmp(32'h0, 32'h1);
		conclude();
	endtask : stall
	// Ends mid-cycle so pin checks see settled levels
	task automatic cyc(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask : cyc
	// Ready is looked at mid-cycle; nothing moves before the next rise
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		@(posedge CLK_SYS);
		AWADDR <= a;
		AWVALID <= 1'h1;
		WDATA <= d;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge CLK_SYS);
			ta = AWVALID && AWREADY;
			tw = WVALID && WREADY;
			tb = BVALID;
			resp = BRESP;
			@(posedge CLK_SYS);
			if (ta) AWVALID <= 1'h0;
			if (tw) WVALID <= 1'h0;
			if (tb) break;
		end
		BREADY <= 1'h0;
		if (n == 40) stall();
	endtask : wr
	task automatic rd(input logic [11:0] a);
		int n;
		logic ta, tr;
		@(posedge CLK_SYS);
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(negedge CLK_SYS);
			ta = ARVALID && ARREADY;
			tr = RVALID;
			rd_data = RDATA;
			resp = RRESP;
			@(posedge CLK_SYS);
			if (ta) ARVALID <= 1'h0;
			if (tr) break;
		end
		RREADY <= 1'h0;
		if (n == 40) stall();
	endtask : rd
	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		cmp(rd_data, e);
	endtask : chk
	// Stop, clear flags, load A and control, then start if asked
	task automatic go(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p,
		input logic on);
		wr(`STM_OFS_CTRL0, 32'h0);
		wr(`STM_OFS_FLAGS, 32'h3);
		wr(`STM_OFS_COMPARE_A_VALUE, {22'h0, a});
		wr(`STM_OFS_CTRL1, {24'h0, c1});
		wr(`STM_OFS_CTRL0, {28'h0, on, p});
	endtask : go

	// Main sequence
	initial begin
		NRST = 1'h0;
		CE = 1'h1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
		{AWADDR, ARADDR, WDATA} = 56'h0;
		WSTRB = 4'hF;
		repeat (6) @(posedge CLK_SYS);
		NRST <= 1'h1;
		// Reset values, then an unmapped word both ways
		for (k = 0; k <= 16; k += 4) chk(k[11:0], 32'h0);
		cmp(resp, `STM_RESP_OKAY);
		chk(12'h014, 32'h0);
		cmp(resp, `STM_RESP_SLVERR);
		wr(12'h014, 32'hFF);
		cmp(resp, `STM_RESP_SLVERR);
		// Compare: each pin function after the first A match, initial high
		for (k = 0; k < 4; k++) begin
			go({STM_MODE_CMP, k[1:0], 4'h9}, 10'h20, 3'h1, 1'h1);
			cyc(3);
			cmp(TIMER_OUT, 32'h1);
			cyc(45);
			cmp(TIMER_OUT, 32'(4'h5 >> k) & 32'h1);
		end
		// Clear on A with P below A: no P flag
		go({STM_MODE_CMP, 2'h0, 4'h1}, 10'h190, 3'h1, 1'h1);
		cmp(resp, `STM_RESP_OKAY);
		cyc(900);
		chk(`STM_OFS_FLAGS, 32'h1);
		rd(`STM_OFS_COUNT);
		cmp(rd_data <= 32'h190, 32'h1);
		// Both zero: overflow at top, P only; toggle never fires
		go({STM_MODE_CMP, 2'h3, 4'h0}, 10'h0, 3'h0, 1'h1);
		cyc(1100);
		chk(`STM_OFS_FLAGS, 32'h2);
		cmp(TIMER_OUT, 32'h0);
		// Timer/counter: P clears, both flags, pin released
		go({STM_MODE_TMR, 2'h0, 4'h0}, 10'h20, 3'h1, 1'h1);
		cyc(300);
		chk(`STM_OFS_FLAGS, 32'h3);
		rd(`STM_OFS_COUNT);
		cmp(rd_data < 32'h80, 32'h1);
		cmp(TIMER_OUT_EN, 32'h0);
		wr(`STM_OFS_CTRL0, 32'h0);
		rd(`STM_OFS_COUNT);
		keep = rd_data;
		cyc(20);
		chk(`STM_OFS_COUNT, keep);
		// PWM table
		for (k = 0; k < 8; k++) begin
			go(pw_c[k], pw_a[k], pw_p[k], 1'h1);
			cyc(pw_w[k] + 8);
			pm_u.measure(pw_w[k], hi);
			cmp(hi, pw_h[k]);
			chk(`STM_OFS_FLAGS, {30'h0, pw_f[k]});
		end
		// Single pulse from the trigger pin, width set by A
		go(8'hB8, 10'h32, 3'h1, 1'h0);
		fork
			pm_u.trigger();
			pm_u.measure(120, hi);
		join
		cmp(hi >= 48 && hi <= 52, 32'h1);
		chk(`STM_OFS_CTRL0, 32'h1);
		chk(`STM_OFS_FLAGS, 32'h1);
		rd(`STM_OFS_COUNT);
		keep = rd_data;
		cyc(10);
		chk(`STM_OFS_COUNT, keep);
		wr(`STM_OFS_CTRL0, 32'h8);
		cyc(3);
		cmp(TIMER_OUT, 32'h1);
		rd(`STM_OFS_COUNT);
		cmp(rd_data < 32'h10, 32'h1);
		wr(`STM_OFS_CTRL0, 32'h0);
		cyc(3);
		cmp(TIMER_OUT, 32'h0);
		// Capture: each edge selection, rise then fall
		for (k = 0; k < 4; k++) begin
			go({STM_MODE_CAP, k[1:0], 4'h0}, 10'h0, 3'h0, 1'h1);
			cyc(40);
			pm_u.set_cap(1'h1);
			rd(`STM_OFS_FLAGS);
			cmp(rd_data[0], 32'(4'h5 >> k) & 32'h1);
			rd(`STM_OFS_COMPARE_A_VALUE);
			if (k == 0) cmp(rd_data >= 32'h28 && rd_data <= 32'h3C, 32'h1);
			wr(`STM_OFS_FLAGS, 32'h3);
			pm_u.set_cap(1'h0);
			rd(`STM_OFS_FLAGS);
			cmp(rd_data[0], 32'(4'h6 >> k) & 32'h1);
		end
		rd(`STM_OFS_COUNT);
		keep = rd_data;
		chk(`STM_OFS_COMPARE_A_VALUE, 32'h0);
		rd(`STM_OFS_COUNT);
		cmp(rd_data > keep, 32'h1);
		// Capture with P: counter wraps at 128 and flags P
		go({STM_MODE_CAP, 2'h3, 4'h0}, 10'h0, 3'h1, 1'h1);
		cyc(300);
		chk(`STM_OFS_FLAGS, 32'h2);
		rd(`STM_OFS_COUNT);
		cmp(rd_data < 32'h80, 32'h1);
		conclude();
	end
endmodule : tb_stm_timer
